// *** logic/orn_pkg.sv ***
// Package: constants, register map and types of the overload restriction block
package orn_pkg;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS  = 4;            // pclk period, 250 MHz
    localparam int DECEL_UNIT_NS  = 100_000_000;  // One decel-time count is 0.1 s
    localparam int UNIT_CYC       = DECEL_UNIT_NS / CLK_PERIOD_NS;
    localparam int MAX_FREQ_DEF   = 40000;        // Max frequency in 0.01 Hz counts
    localparam int STEP_CYC_DEF   = UNIT_CYC / MAX_FREQ_DEF; // Cycles per count per 0.1 s
    localparam int RAMP_CW        = 24;           // Step divider width

    // ==========================================
    // Register offsets
    localparam logic [11:0] OFS_RESTR_A  = 12'h000;
    localparam logic [11:0] OFS_RESTR_B  = 12'h004;
    localparam logic [11:0] OFS_NOTICE   = 12'h008;
    localparam logic [11:0] OFS_CTRL     = 12'h00C;
    localparam logic [11:0] OFS_IN_FN0   = 12'h010;
    localparam logic [11:0] OFS_IN_FN1   = 12'h014;
    localparam logic [11:0] OFS_OUT_FN0  = 12'h018;
    localparam logic [11:0] OFS_OUT_FN1  = 12'h01C;
    localparam logic [11:0] OFS_STATUS   = 12'h020;
    localparam logic [11:0] OFS_FREQ     = 12'h024;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h028;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h02C;

    // ==========================================
    // Field positions and widths
    localparam int CUR_W      = 12;  // Current in 1/1000 of rated current
    localparam int DEC_W      = 9;   // Decel time in 0.1 s
    localparam int MODE_LSB   = 0;
    localparam int LEVEL_LSB  = 4;
    localparam int DECEL_LSB  = 16;
    localparam int NLVL1_LSB  = 4;
    localparam int NLVL2_LSB  = 16;
    localparam int PHASE_BIT  = 0;
    localparam int SURGE_BIT  = 0;
    localparam int N_IN       = 8;   // Input terminals
    localparam int N_OUT      = 6;   // Five output terminals and the relay
    localparam int FN_W       = 6;

    // ==========================================
    // Limits and codes
    localparam logic [CUR_W-1:0] LEVEL_MIN = 12'h0C8;  // 0.2 x rated
    localparam logic [CUR_W-1:0] LEVEL_MAX = 12'h708;  // 1.8 x rated
    localparam logic [DEC_W-1:0] DECEL_MIN = 9'h001;   // 0.1 s
    localparam logic [DEC_W-1:0] DECEL_MAX = 9'h12C;   // 30.0 s
    localparam logic [1:0] MODE_OFF       = 2'h0;
    localparam logic [1:0] MODE_ACC_CONST = 2'h1;
    localparam logic [1:0] MODE_CONST     = 2'h2;
    localparam logic [1:0] MODE_REGEN     = 2'h3;
    localparam logic PH_ALL   = 1'h0;
    localparam logic PH_CONST = 1'h1;
    localparam logic [FN_W-1:0] FN_SET_SELECT = 6'h27;  // 39
    localparam logic [FN_W-1:0] FN_NOTICE1    = 6'h03;
    localparam logic [FN_W-1:0] FN_NOTICE2    = 6'h1A;  // 26

    // ==========================================
    // Reset values
    localparam logic [1:0]       MODE_RST  = 2'h1;
    localparam logic [CUR_W-1:0] LEVEL_RST = 12'h5DC;  // 1.5 x rated
    localparam logic [DEC_W-1:0] DECEL_RST = 9'h00A;   // 1.0 s
    localparam logic [CUR_W-1:0] SURGE_LEVEL_DEF = 12'h708;

    // ==========================================
    // Interrupt bits
    localparam int IRQ_W     = 4;
    localparam int IRQ_RESTR = 0;
    localparam int IRQ_N1    = 1;
    localparam int IRQ_N2    = 2;
    localparam int IRQ_SURGE = 3;

    typedef enum logic [1:0] {FR_FOLLOW, FR_LOWER, FR_RAISE} orn_freq_st_t;
endpackage

// *** logic/orn_ramp_if.sv ***
// Interface: link between the frequency control and the step divider
`timescale 1ns/1ps
interface orn_ramp_if #(parameter int CW = 24);
    logic          run;     // Divider counts while high
    logic [CW-1:0] period;  // Cycles between steps
    logic          step;    // One-cycle step enable
    modport ctl (output run, output period, input step);
    modport gen (input run, input period, output step);
endinterface

// *** logic/orn_step_gen.sv ***
// Step divider: one-cycle enable every period cycles while running
`timescale 1ns/1ps
module orn_step_gen
    import orn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    orn_ramp_if.gen  ramp
);
    logic [RAMP_CW-1:0] cnt;  // Cycles since last step

    // ==========================================
    // Divider; restarts from zero whenever run drops so the first step is a full period away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= '0;
            ramp.step <= 1'b0;
        end else if (!ramp.run) begin
            cnt       <= '0;
            ramp.step <= 1'b0;
        end else if (cnt + 1'b1 >= ramp.period) begin
            cnt       <= '0;
            ramp.step <= 1'b1;
        end else begin
            cnt       <= cnt + 1'b1;
            ramp.step <= 1'b0;
        end
    end
endmodule

// *** logic/orn_top.sv ***
// Overload restriction, overload notice and surge restraint with APB registers
`timescale 1ns/1ps
module orn_top
    import orn_pkg::*;
#(
    parameter int               MAX_FREQ    = MAX_FREQ_DEF,
    parameter int               STEP_CYC    = STEP_CYC_DEF,
    parameter logic [CUR_W-1:0] SURGE_LEVEL = SURGE_LEVEL_DEF
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire logic [N_IN-1:0]  in_term,        // Input terminals
    input  wire logic [CUR_W-1:0] motor_current,  // 1/1000 of rated
    input  wire logic [15:0]      freq_cmd,       // Ramp generator output
    input  wire logic             accel,
    input  wire logic             decel,
    input  wire logic             regen,
    input  wire logic             vector_ctrl,
    output logic [15:0]           freq_out,
    output logic                  restricting,
    output logic                  accel_hold,     // Surge restraint pauses acceleration
    output logic [N_OUT-1:0]      out_term,
    output logic                  irq
);
    // ==========================================
    // Registers
    logic [1:0]       mode_a, mode_b;                 // Restriction modes
    logic [CUR_W-1:0] lvl_a, lvl_b;                   // Restriction levels
    logic [DEC_W-1:0] dec_a, dec_b;                   // Decel times
    logic             notice_phase_select;
    logic [CUR_W-1:0] notice_level_first;
    logic [CUR_W-1:0] notice_level_second;
    logic             surge_restraint_enable;
    logic [FN_W-1:0]  in_func  [N_IN];                // Input terminal functions
    logic [FN_W-1:0]  out_func [N_OUT];               // Output terminal functions
    logic [IRQ_W-1:0] irq_stat, irq_mask;
    logic             notice_first, notice_second;
    orn_freq_st_t     state, next_state;

    // ==========================================
    // Bus decode
    wire wr_en = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire hit = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 && paddr[5:2] <= 4'hB;
    wire wr_a   = wr_en && paddr == OFS_RESTR_A;
    wire wr_b   = wr_en && paddr == OFS_RESTR_B;
    wire wr_n   = wr_en && paddr == OFS_NOTICE;
    wire wr_c   = wr_en && paddr == OFS_CTRL;
    wire wr_if0 = wr_en && paddr == OFS_IN_FN0;
    wire wr_if1 = wr_en && paddr == OFS_IN_FN1;
    wire wr_of0 = wr_en && paddr == OFS_OUT_FN0;
    wire wr_of1 = wr_en && paddr == OFS_OUT_FN1;
    wire wr_is  = wr_en && paddr == OFS_IRQ_STAT;
    wire wr_im  = wr_en && paddr == OFS_IRQ_MASK;

    // No wait states; a miss answers with an error and zero data
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ==========================================
    // Write clamping keeps settings inside their legal span
    function automatic logic [CUR_W-1:0] clamp_lvl(input logic [CUR_W-1:0] v);
        clamp_lvl = (v < LEVEL_MIN) ? LEVEL_MIN : (v > LEVEL_MAX) ? LEVEL_MAX : v;
    endfunction
    function automatic logic [DEC_W-1:0] clamp_dec(input logic [DEC_W-1:0] v);
        clamp_dec = (v < DECEL_MIN) ? DECEL_MIN : (v > DECEL_MAX) ? DECEL_MAX : v;
    endfunction
    function automatic logic [CUR_W-1:0] clamp_ntc(input logic [CUR_W-1:0] v);
        clamp_ntc = (v > LEVEL_MAX) ? LEVEL_MAX : v;
    endfunction

    // ==========================================
    // Restriction sets, two independent copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_a <= MODE_RST;
            lvl_a  <= LEVEL_RST;
            dec_a  <= DECEL_RST;
            mode_b <= MODE_RST;
            lvl_b  <= LEVEL_RST;
            dec_b  <= DECEL_RST;
        end else begin
            if (wr_a) begin
                mode_a <= pwdata[MODE_LSB +: 2];
                lvl_a  <= clamp_lvl(pwdata[LEVEL_LSB +: CUR_W]);
                dec_a  <= clamp_dec(pwdata[DECEL_LSB +: DEC_W]);
            end
            if (wr_b) begin
                mode_b <= pwdata[MODE_LSB +: 2];
                lvl_b  <= clamp_lvl(pwdata[LEVEL_LSB +: CUR_W]);
                dec_b  <= clamp_dec(pwdata[DECEL_LSB +: DEC_W]);
            end
        end
    end

    // ==========================================
    // Notice and control settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notice_phase_select    <= PH_ALL;
            notice_level_first     <= '0;
            notice_level_second    <= '0;
            surge_restraint_enable <= 1'b0;
        end else begin
            if (wr_n) begin
                notice_phase_select <= pwdata[PHASE_BIT];
                notice_level_first  <= clamp_ntc(pwdata[NLVL1_LSB +: CUR_W]);
                notice_level_second <= clamp_ntc(pwdata[NLVL2_LSB +: CUR_W]);
            end
            if (wr_c) begin
                surge_restraint_enable <= pwdata[SURGE_BIT];
            end
        end
    end

    // ==========================================
    // Terminal function bytes, four to a word
    logic [63:0] in_pack, out_pack;
    logic [N_IN-1:0] sel_hits;
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            wire wr_this = (gi < 4) ? wr_if0 : wr_if1;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_func[gi] <= '0;
                end else if (wr_this) begin
                    in_func[gi] <= pwdata[8*(gi%4) +: FN_W];
                end
            end
            assign in_pack[8*gi +: 8] = {2'h0, in_func[gi]};
            assign sel_hits[gi] = in_term[gi] && in_func[gi] == FN_SET_SELECT;
        end
    endgenerate

    // ==========================================
    // Selected parameter set
    wire              set_b    = |sel_hits;
    wire [1:0]        mode_sel = set_b ? mode_b : mode_a;
    wire [CUR_W-1:0]  lvl_sel  = set_b ? lvl_b : lvl_a;
    wire [DEC_W-1:0]  dec_sel  = set_b ? dec_b : dec_a;

    // ==========================================
    // Phase and trip decode
    wire phase_const = !accel && !decel;
    wire over        = motor_current >= lvl_sel;
    wire restr_en    = (mode_sel == MODE_ACC_CONST || mode_sel == MODE_REGEN) ? (accel || phase_const) :
                       (mode_sel == MODE_CONST) ? phase_const : 1'b0;
    wire regen_raise = mode_sel == MODE_REGEN && vector_ctrl && regen;
    wire lower_trip  = restr_en && over && !regen_raise;
    wire raise_trip  = regen_raise && over;

    // ==========================================
    // Step divider; period spans one count at the selected decel rate
    orn_ramp_if #(.CW(RAMP_CW)) ramp ();
    assign ramp.run    = state != FR_FOLLOW;
    assign ramp.period = RAMP_CW'(dec_sel) * RAMP_CW'(STEP_CYC);
    orn_step_gen u_step (
        .pclk    (pclk),
        .presetn (presetn),
        .ramp    (ramp)
    );

    // ==========================================
    // Frequency control state
    always_comb begin
        next_state = state;
        case (state)
            FR_FOLLOW: begin
                if (raise_trip) begin
                    next_state = FR_RAISE;
                end else if (lower_trip) begin
                    next_state = FR_LOWER;
                end
            end
            FR_LOWER: begin
                if (!lower_trip) begin
                    next_state = FR_FOLLOW;
                end
            end
            FR_RAISE: begin
                if (!raise_trip) begin
                    next_state = FR_FOLLOW;
                end
            end
            default: begin
                next_state = FR_FOLLOW;
            end
        endcase
    end

    // Releasing hands back to the ramp generator, which must track freq_out to avoid a jump
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= FR_FOLLOW;
            freq_out    <= '0;
            restricting <= 1'b0;
        end else begin
            state       <= next_state;
            restricting <= next_state != FR_FOLLOW;
            if (state == FR_FOLLOW) begin
                freq_out <= freq_cmd;
            end else if (state == FR_LOWER && ramp.step && freq_out != 16'h0000) begin
                freq_out <= freq_out - 16'h0001;
            end else if (state == FR_RAISE && ramp.step && 32'(freq_out) < MAX_FREQ) begin
                freq_out <= freq_out + 16'h0001;
            end
        end
    end

    // ==========================================
    // Overload notices
    wire notice_ok = notice_phase_select == PH_ALL || phase_const;
    wire n1_hit = notice_level_first != '0 && notice_ok && motor_current >= notice_level_first;
    wire n2_hit = notice_level_second != '0 && notice_ok && motor_current >= notice_level_second;
    wire surge_hit = surge_restraint_enable && accel && motor_current >= SURGE_LEVEL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notice_first  <= 1'b0;
            notice_second <= 1'b0;
            accel_hold    <= 1'b0;
        end else begin
            notice_first  <= n1_hit;
            notice_second <= n2_hit;
            accel_hold    <= surge_hit;
        end
    end

    // ==========================================
    // Output terminals carry whichever notice their code names
    genvar go;
    generate
        for (go = 0; go < N_OUT; go++) begin : g_out
            wire wr_this = (go < 4) ? wr_of0 : wr_of1;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_func[go] <= '0;
                    out_term[go] <= 1'b0;
                end else begin
                    if (wr_this) begin
                        out_func[go] <= pwdata[8*(go%4) +: FN_W];
                    end
                    out_term[go] <= (out_func[go] == FN_NOTICE1) ? n1_hit :
                                    (out_func[go] == FN_NOTICE2) ? n2_hit : 1'b0;
                end
            end
            assign out_pack[8*go +: 8] = {2'h0, out_func[go]};
        end
        for (go = N_OUT; go < 8; go++) begin : g_pad
            assign out_pack[8*go +: 8] = 8'h00;
        end
    endgenerate

    // ==========================================
    // Interrupts; a new event in the clearing cycle stays set
    wire [IRQ_W-1:0] ev;
    assign ev[IRQ_RESTR] = state == FR_FOLLOW && next_state != FR_FOLLOW;
    assign ev[IRQ_N1]    = n1_hit && !notice_first;
    assign ev[IRQ_N2]    = n2_hit && !notice_second;
    assign ev[IRQ_SURGE] = surge_hit && !accel_hold;
    wire [IRQ_W-1:0] clr = wr_is ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= (irq_stat & ~clr) | ev;
            if (wr_im) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // ==========================================
    // Read selection, registered in the setup cycle
    wire [31:0] st_word = {27'h0, accel_hold, set_b, notice_second, notice_first, restricting};
    wire [31:0] rd_mux =
        paddr == OFS_RESTR_A  ? {7'h0, dec_a, lvl_a, 2'h0, mode_a} :
        paddr == OFS_RESTR_B  ? {7'h0, dec_b, lvl_b, 2'h0, mode_b} :
        paddr == OFS_NOTICE   ? {4'h0, notice_level_second, notice_level_first, 3'h0, notice_phase_select} :
        paddr == OFS_CTRL     ? {31'h0, surge_restraint_enable} :
        paddr == OFS_IN_FN0   ? in_pack[31:0] :
        paddr == OFS_IN_FN1   ? in_pack[63:32] :
        paddr == OFS_OUT_FN0  ? out_pack[31:0] :
        paddr == OFS_OUT_FN1  ? out_pack[63:32] :
        paddr == OFS_STATUS   ? st_word :
        paddr == OFS_FREQ     ? {16'h0, freq_out} :
        paddr == OFS_IRQ_STAT ? {28'h0, irq_stat} :
        paddr == OFS_IRQ_MASK ? {28'h0, irq_mask} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_off_idle: assert property (state == FR_FOLLOW && mode_sel == MODE_OFF |=> state == FR_FOLLOW)
        else $error("restriction entered with mode off");
    a_lower_step: assert property (state == FR_LOWER && ramp.step && freq_out != 16'h0000
        |=> freq_out == $past(freq_out) - 16'h0001)
        else $error("frequency not lowered on step");
    a_set_pick: assert property (set_b && mode_b == MODE_OFF |=> !restricting)
        else $error("second set not selected");
    a_level_span: assert property (lvl_a >= LEVEL_MIN && lvl_a <= LEVEL_MAX && lvl_b >= LEVEL_MIN && lvl_b <= LEVEL_MAX)
        else $error("restriction level out of span");
    a_decel_span: assert property (dec_sel >= DECEL_MIN && dec_sel <= DECEL_MAX)
        else $error("decel time out of span");
    a_regen_step: assert property (state == FR_RAISE && ramp.step && 32'(freq_out) < MAX_FREQ
        |=> freq_out == $past(freq_out) + 16'h0001)
        else $error("frequency not raised on regen step");
    a_term_map: assert property (out_func[0] == FN_NOTICE1 && $stable(out_func[0])
        |-> out_term[0] == notice_first)
        else $error("terminal does not carry first notice");
    a_phase_gate: assert property (notice_phase_select == PH_CONST && (accel || decel) |=> !notice_first)
        else $error("notice outside constant speed");
    a_first_off: assert property (notice_level_first == '0 |=> !notice_first)
        else $error("first notice with zero level");
    a_second_off: assert property (notice_level_second == '0 |=> !notice_second)
        else $error("second notice with zero level");
    a_surge_off: assert property (!surge_restraint_enable |=> !accel_hold)
        else $error("surge hold while disabled");
    a_notice_drop: assert property (motor_current < notice_level_first |=> !notice_first)
        else $error("first notice held below level");
endmodule

// *** testbench/orn_motor_model.sv ***
// Partner model: motor whose phase current follows the load the bench demands
`timescale 1ns/1ps
module orn_motor_model
    import orn_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [CUR_W-1:0] load,          // Demanded current, 1/1000 rated
    output logic      [CUR_W-1:0] motor_current  // Measured current
);
    // ==========================================
    // Current sensing
    // One cycle of sensing lag; no hoisting load is modelled, so restraint may stay on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_current <= '0;  // Motor at rest
        end else begin
            motor_current <= load;
        end
    end
endmodule

// *** testbench/orn_top_tb.sv ***
// Testbench: APB set-up, restriction, notice, interrupt and surge scenarios
`timescale 1ns/1ps
module orn_top_tb
    import orn_pkg::*;
;
    // ==========================================
    // Stimulus and observation
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, accel = 0, decel = 0, regen = 0, vec = 0;
    logic restricting, accel_hold, irq, err;
    logic [N_IN-1:0] in_term = '0;
    logic [CUR_W-1:0] load = '0, cur;
    logic [15:0] freq_cmd = 16'h03E8, freq_out;
    logic [N_OUT-1:0] out_term;
    int errors = 0, n_checks = 0;
    always #2 pclk = ~pclk;  // 250 MHz
    orn_motor_model mot (.pclk(pclk), .presetn(presetn), .load(load), .motor_current(cur));
    orn_top #(.STEP_CYC(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .in_term(in_term), .motor_current(cur), .freq_cmd(freq_cmd),
        .accel(accel), .decel(decel), .regen(regen), .vector_ctrl(vec), .freq_out(freq_out),
        .restricting(restricting), .accel_hold(accel_hold), .out_term(out_term), .irq(irq));
    // ==========================================
    // Shared tasks
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Lets model lag and registered outputs settle
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    // Reset values, clamping at both ends, unmapped access
    task automatic t_regs;
        apb(0, OFS_RESTR_A, 0); chk(q, 32'h000A5DC1);
        chk(err, 0);
        apb(1, OFS_RESTR_B, 32'h00000642); apb(0, OFS_RESTR_B, 0); chk(q, 32'h00010C82);
        apb(1, OFS_RESTR_B, 32'h01907D02); apb(0, OFS_RESTR_B, 0); chk(q, 32'h012C7082);
        apb(0, 12'h030, 0); chk(err, 1);
        $display("t_regs done");
    endtask
    // Every mode code in accel and in constant speed, then set selection
    task automatic t_modes;
        load <= 12'h640;
        for (int m = 0; m < 4; m++) begin
            apb(1, OFS_RESTR_A, 32'h000A5DC0 | m);
            accel <= 1; settle(4); chk(restricting, m == 1 || m == 3);
            accel <= 0; settle(4); chk(restricting, m != 0);
            decel <= 1; settle(4); chk(restricting, 0);
            decel <= 0;
        end
        apb(1, OFS_RESTR_A, 32'h000A5DC1);
        apb(1, OFS_RESTR_B, 32'h000A5DC0);
        apb(1, OFS_IN_FN0, 32'h00000027);
        in_term <= 8'h01; settle(4); chk(restricting, 0);
        in_term <= 8'h00; settle(4); chk(restricting, 1);
        load <= 0; settle(4);
        $display("t_modes done");
    endtask
    // Lowering, recovery, and raising in regeneration
    task automatic t_ramp;
        apb(1, OFS_RESTR_A, 32'h00015DC1);
        load <= 12'h640; settle(30); chk(freq_out < 16'h03E8, 1);
        load <= 0; settle(4); chk(freq_out, 16'h03E8);
        apb(1, OFS_RESTR_A, 32'h00015DC3);
        vec <= 1; regen <= 1; load <= 12'h640; settle(30); chk(freq_out > 16'h03E8, 1);
        load <= 0; vec <= 0; regen <= 0; settle(4);
        $display("t_ramp done");
    endtask
    // Notice outputs, phase gating, disabled level, interrupt
    task automatic t_notice;
        apb(1, OFS_NOTICE, 32'h00003E81);
        apb(1, OFS_OUT_FN0, 32'h00001A03);
        apb(1, OFS_IRQ_MASK, 32'h00000002);
        load <= 12'h44C; settle(4); chk(out_term[1:0], 2'b01);
        chk(irq, 1);
        apb(1, OFS_IRQ_STAT, 32'h00000002); settle(1); chk(irq, 0);
        accel <= 1; settle(4); chk(out_term[0], 0);
        accel <= 0; load <= 12'h384; settle(4); chk(out_term[0], 0);
        apb(1, OFS_NOTICE, 32'h041A3E80);
        load <= 12'h44C; accel <= 1; settle(4); chk(out_term[1:0], 2'b11);
        accel <= 0; load <= 0; settle(4);
        $display("t_notice done");
    endtask
    // Surge restraint on and off
    task automatic t_surge;
        apb(1, OFS_RESTR_A, 32'h000A5DC0);
        apb(1, OFS_CTRL, 32'h00000001);
        accel <= 1; load <= 12'h708; settle(4); chk(accel_hold, 1);
        apb(1, OFS_CTRL, 32'h00000000); settle(2); chk(accel_hold, 0);
        accel <= 0; load <= 0;
        $display("t_surge done");
    endtask
    // Mid-run reset restores settings changed by earlier scenarios
    task automatic t_reset;
        presetn <= 0; settle(2); chk(restricting, 0);
        presetn <= 1;
        apb(0, OFS_RESTR_A, 0); chk(q, 32'h000A5DC1);
        apb(0, OFS_NOTICE, 0); chk(q, 32'h00000000);
        $display("t_reset done");
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        settle(3);
        presetn <= 1;
        t_regs; t_modes; t_ramp; t_notice; t_surge; t_reset;
        wrap_up;
    end
    // Whole run is about 240 cycles; over eighty times that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        wrap_up;
    end
endmodule
